/* File: msl_pkg.sv */
// Shared constants, states and carriers of the swappable module lifecycle control
package msl_pkg;
    localparam int MOD_COUNT = 4;
    localparam int MOD_W     = 2;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int CAP_W     = 32;
    localparam int DUR_W     = 8;
    localparam int STATE_W   = 3;

    localparam logic [ADDR_W-1:0] ADDR_CONTROL  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_OPTIONS  = 8'h08;
    localparam logic [3:0]        CFG_PAGE      = 4'h1;

    localparam int CTL_PROCEED  = 0;
    localparam int CTL_LOAD     = 1;
    localparam int CTL_SHUTDOWN = 2;
    localparam int CTL_RESTART  = 3;
    localparam int CTL_ISO_VAL  = 4;
    localparam int CTL_ISO_WE   = 5;
    localparam int CTL_RST_VAL  = 6;
    localparam int CTL_RST_WE   = 7;
    localparam int CTL_MOD_LSB  = 8;

    localparam int STS_STATE_LSB = 0;
    localparam int STS_FULL      = 4;
    localparam int STS_MOD_LSB   = 8;
    localparam int STS_ISO       = 12;
    localparam int STS_RST       = 13;
    localparam int STS_START     = 14;
    localparam int STS_REQ       = 15;

    localparam int CFG_START_EN = 0;
    localparam int CFG_RST_EN   = 1;
    localparam int CFG_RST_HIGH = 2;
    localparam int CFG_DUR_LSB  = 8;
    localparam int OPT_SKIP     = 0;

    localparam logic [1:0] ARB_OFF    = 2'h0;
    localparam logic [1:0] ARB_NO_LAT = 2'h1;
    localparam logic [1:0] ARB_LAT    = 2'h2;

    typedef struct packed {
        logic [DUR_W-1:0] dur;
        logic             rst_high;
        logic             rst_en;
        logic             start_en;
    } msl_cfg_t;

    localparam msl_cfg_t CFG_RESET = '{dur: 8'h04, rst_high: 1'b1,
                                       rst_en: 1'b1, start_en: 1'b1};
    localparam logic             FULL_RESET = 1'b0;
    localparam logic             ISO_RESET  = 1'b1;
    localparam logic             SKIP_RESET = 1'b0;
    localparam logic             RST_OUT_RESET = 1'b0;
    localparam logic [DUR_W-1:0] DUR_ONE    = 8'h01;

    typedef enum logic [STATE_W-1:0] {
        ST_BOOT, ST_IDLE, ST_LOAD, ST_STARTUP, ST_RELEASE, ST_MODRESET,
        ST_SHUTDOWN
    } msl_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } msl_bus_t;

    typedef struct packed {
        logic [CAP_W-1:0] data;
        logic             valid;
        logic             last;
    } msl_bs_t;
endpackage

/* File: msl_cap_arb.sv */
// Request and yield handshake toward the configuration access port arbiter
`timescale 1ns/1ns
module msl_cap_arb import msl_pkg::*; #(
    parameter logic [1:0] ARB_MODE = ARB_NO_LAT
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_ce,
    // Load engine
    input  wire logic i_have_data,
    output logic      o_xfer,
    // Arbiter
    input  wire logic i_grant,
    input  wire logic i_release,
    output logic      o_req
);
    typedef struct packed {
        logic req;
        logic gnt_seen;
    } msl_arb_st_t;

    msl_arb_st_t q, d;

    always_comb begin
        d = q;
        d.req = 1'b0;
        d.gnt_seen = 1'b0;
        if (ARB_MODE != ARB_OFF) begin
            // A new request waits out a pending release; one in flight
            // keeps going so the load under way finishes.
            d.req = i_have_data && !(i_release && !q.req);
            d.gnt_seen = q.req && (i_grant || q.gnt_seen);
            if (ARB_MODE == ARB_LAT && q.gnt_seen && !i_grant) begin
                d.req = 1'b0;
            end
            // In mode 1 a standing grant is simply reused.
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            q <= '0;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_req  = q.req;
    assign o_xfer = (ARB_MODE == ARB_OFF) ? i_have_data
                                          : (q.req && i_grant);
endmodule

/* File: msl_reset_timer.sv */
// Timed, polarity-aware reset pulse toward the loaded swappable module
`timescale 1ns/1ns
module msl_reset_timer import msl_pkg::*; (
    // Clock and power-on reset
    input  wire logic             i_clk,
    input  wire logic             i_power_on_reset,
    input  wire logic             i_ce,
    // Control
    input  wire logic             i_start,
    input  wire logic [DUR_W-1:0] i_dur,
    input  wire logic             i_high,
    input  wire logic             i_force_we,
    input  wire logic             i_force_val,
    input  wire logic             i_clear,
    // Result
    output logic                  o_reset_out,
    output logic                  o_asserted,
    output logic                  o_done
);
    typedef struct packed {
        logic             asserted;
        logic [DUR_W-1:0] cnt;
        logic             out;
        logic             done;
    } msl_tmr_st_t;

    msl_tmr_st_t q, d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        if (i_start) begin
            d.asserted = 1'b1;
            d.cnt = (i_dur == '0) ? DUR_ONE : i_dur;
        end else if (i_force_we) begin
            d.asserted = i_force_val;
            d.cnt = '0;
        end else if (i_clear) begin
            d.asserted = 1'b0;
            d.cnt = '0;
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - DUR_ONE;
            if (q.cnt == DUR_ONE) begin
                d.asserted = 1'b0;
                d.done = 1'b1;
            end
        end
        d.out = d.asserted ? i_high : ~i_high;
    end

    // Only power-on clears it, so a core reset leaves the level alone
    always_ff @(posedge i_clk or posedge i_power_on_reset) begin
        if (i_power_on_reset) begin
            q <= '{asserted: 1'b0, cnt: '0, out: RST_OUT_RESET,
                   done: 1'b0};
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_reset_out = q.out;
    assign o_asserted  = q.asserted;
    assign o_done      = q.done;
endmodule

/* File: msl_lifecycle_ctrl.sv */
// Socket lifecycle sequencer with register port and port arbitration
//
// How it works
// - After a load, raise the start-up request toward software.
// - Start-up comes after load, before module reset and isolate release.
// - Start-up step is enabled per module in its configuration word.
// - Arbitration mode parameter: off, no added latency, added latency.
// - Request the port every cycle while load data remains.
// - A word moves only when request and grant are both high.
// - On release, finish the current load, then drop request.
// - Mode 1: grant may stay high and a new request follows at once.
// - Mode 2: grant falls after a transfer and request follows it down.
// - Isolate is high while the socket is empty or in start-up after a load, low otherwise.
// - Isolate rises at load start and holds until start-up completes.
// - Core reset forces isolate to empty-high or full-low.
// - Start-up after core reset with socket full keeps isolate low.
// - Shutdown state keeps isolate but lets software write it.
// - Leaving shutdown sets isolate from occupancy, dropping written value.
// - Module reset enable, polarity and length are set per module.
// - Module reset follows a load, after start-up when enabled.
// - Core reset with socket full pulses module reset unless skipped.
// - Module reset is writable in shutdown only; core reset leaves it.
// - Module reset asserts the cycle after isolate falls.
`timescale 1ns/1ns
module msl_lifecycle_ctrl import msl_pkg::*; #(
    parameter logic [1:0] ARB_MODE = ARB_NO_LAT
) (
    // Clock, resets and enable
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic              i_power_on_reset,
    input  wire logic              i_ce,
    // Register port
    input  wire msl_bus_t          i_bus,
    output logic [DATA_W-1:0]      o_rdata,
    // Bitstream words in
    input  wire msl_bs_t           i_bs,
    output logic                   o_bs_ready,
    // Configuration access port
    output logic [CAP_W-1:0]       o_cap_data,
    output logic                   o_cap_write,
    output logic                   o_cap_req,
    input  wire logic              i_cap_grant,
    input  wire logic              i_cap_release,
    // Toward the swappable module and software
    output logic                   o_module_startup_sw_request,
    output logic                   o_module_isolate,
    output logic                   o_module_reset_out
);
    typedef struct packed {
        msl_state_t        state;
        logic              after_boot;
        logic              started;
        logic [MOD_W-1:0]  load_id;
        logic [CAP_W-1:0]  hold;
        logic              hold_v;
        logic              hold_last;
        logic              ready;
        logic [CAP_W-1:0]  cap_data;
        logic              cap_we;
        logic              cap_last;
        logic              startup_req;
        logic [DATA_W-1:0] rdata;
    } msl_core_t;

    // Survives a core reset: occupancy, isolate level and configuration
    typedef struct packed {
        logic                            full;
        logic [MOD_W-1:0]                mod_id;
        logic                            isolate;
        logic                            skip;
        msl_cfg_t [MOD_COUNT-1:0]        cfg;
    } msl_keep_t;

    msl_core_t core_q, core_d;
    msl_keep_t keep_q, keep_d;

    logic             ctl_wr;
    logic             opt_wr;
    logic             cfg_hit;
    logic [MOD_W-1:0] cfg_idx;
    logic             have_data;
    logic             arb_xfer;
    logic             tmr_start;
    logic             tmr_force;
    logic             tmr_clear;
    logic             tmr_asserted;
    logic             tmr_done;
    logic             ev_load_go;
    logic             ev_loaded;
    logic             ev_release;
    logic             ev_restart;
    logic             in_shutdown;
    logic             req_seen;
    msl_cfg_t         cur_cfg;
    msl_cfg_t         new_cfg;

    assign ctl_wr  = i_bus.we && (i_bus.addr == ADDR_CONTROL);
    assign opt_wr  = i_bus.we && (i_bus.addr == ADDR_OPTIONS);
    assign cfg_hit = (i_bus.addr[ADDR_W-1:4] == CFG_PAGE)
                     && (i_bus.addr[1:0] == 2'h0);
    assign cfg_idx = i_bus.addr[3:2];
    assign cur_cfg = keep_q.cfg[keep_q.mod_id];
    assign new_cfg = keep_q.cfg[core_q.load_id];
    assign in_shutdown = (core_q.state == ST_SHUTDOWN);

    // Request stays up until the last word has actually left
    assign have_data = (core_q.state == ST_LOAD)
                       && !(core_q.hold_last && !core_q.hold_v);

    assign ev_load_go = (core_q.state == ST_IDLE)
                        && (core_d.state == ST_LOAD);
    assign ev_loaded  = (core_q.state == ST_LOAD)
                        && core_q.cap_we && core_q.cap_last;
    assign ev_release = (core_q.state == ST_RELEASE);
    assign ev_restart = in_shutdown && (core_d.state == ST_IDLE);

    // Start one cycle after entering the reset state, isolate already low
    assign tmr_start = (core_q.state == ST_MODRESET)
                       && !core_q.started;
    assign tmr_force = in_shutdown && ctl_wr
                       && i_bus.wdata[CTL_RST_WE];
    assign tmr_clear = ev_restart;

    msl_cap_arb #(
        .ARB_MODE (ARB_MODE)
    ) u_arb (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_ce        (i_ce),
        .i_have_data (have_data),
        .o_xfer      (arb_xfer),
        .i_grant     (i_cap_grant),
        .i_release   (i_cap_release),
        .o_req       (o_cap_req)
    );

    msl_reset_timer u_tmr (
        .i_clk            (i_clk),
        .i_power_on_reset (i_power_on_reset),
        .i_ce             (i_ce),
        .i_start          (tmr_start),
        .i_dur            (cur_cfg.dur),
        .i_high           (cur_cfg.rst_high),
        .i_force_we       (tmr_force),
        .i_force_val      (i_bus.wdata[CTL_RST_VAL]),
        .i_clear          (tmr_clear),
        .o_reset_out      (o_module_reset_out),
        .o_asserted       (tmr_asserted),
        .o_done           (tmr_done)
    );

    assign req_seen = o_cap_req;

    // Sequencer, load engine and read path
    always_comb begin
        core_d = core_q;
        core_d.cap_we = 1'b0;
        core_d.rdata = '0;
        unique case (core_q.state)
            ST_BOOT: begin
                core_d.after_boot = 1'b1;
                if (keep_q.full && !keep_q.skip
                    && cur_cfg.start_en) begin
                    core_d.state = ST_STARTUP;
                    core_d.startup_req = 1'b1;
                end else if (keep_q.full && !keep_q.skip
                             && cur_cfg.rst_en) begin
                    core_d.state = ST_MODRESET;
                end else begin
                    core_d.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                core_d.after_boot = 1'b0;
                if (ctl_wr && i_bus.wdata[CTL_LOAD]) begin
                    core_d.state = ST_LOAD;
                    core_d.load_id = i_bus.wdata[CTL_MOD_LSB +: MOD_W];
                    core_d.hold_v = 1'b0;
                    core_d.hold_last = 1'b0;
                    core_d.cap_last = 1'b0;
                end else if (ctl_wr && i_bus.wdata[CTL_SHUTDOWN]) begin
                    core_d.state = ST_SHUTDOWN;
                end
            end
            ST_LOAD: begin
                if (core_q.hold_v && arb_xfer) begin
                    core_d.cap_we = 1'b1;
                    core_d.cap_data = core_q.hold;
                    core_d.cap_last = core_q.hold_last;
                    core_d.hold_v = 1'b0;
                end else if (core_q.ready && i_bs.valid) begin
                    core_d.hold = i_bs.data;
                    core_d.hold_last = i_bs.last;
                    core_d.hold_v = 1'b1;
                end
                if (ev_loaded) begin
                    if (new_cfg.start_en) begin
                        core_d.state = ST_STARTUP;
                        core_d.startup_req = 1'b1;
                    end else begin
                        core_d.state = ST_RELEASE;
                    end
                end
            end
            ST_STARTUP: begin
                // No timeout: software may take as long as it needs
                if (ctl_wr && i_bus.wdata[CTL_PROCEED]) begin
                    core_d.startup_req = 1'b0;
                    if (!core_q.after_boot) begin
                        core_d.state = ST_RELEASE;
                    end else if (cur_cfg.rst_en) begin
                        core_d.state = ST_MODRESET;
                    end else begin
                        core_d.state = ST_IDLE;
                    end
                end
            end
            ST_RELEASE: begin
                core_d.state = cur_cfg.rst_en ? ST_MODRESET
                                              : ST_IDLE;
            end
            ST_MODRESET: begin
                core_d.started = 1'b1;
                if (tmr_done) begin
                    core_d.state = ST_IDLE;
                    core_d.started = 1'b0;
                end
            end
            ST_SHUTDOWN: begin
                if (ctl_wr && i_bus.wdata[CTL_RESTART]) begin
                    core_d.state = ST_IDLE;
                end
            end
        endcase
        // Half-rate intake: one holding word keeps the ready a flop
        core_d.ready = (core_d.state == ST_LOAD) && !core_d.hold_v
                       && !core_d.hold_last;
        if (i_bus.re) begin
            if (i_bus.addr == ADDR_STATUS) begin
                core_d.rdata[STS_STATE_LSB +: STATE_W] = core_q.state;
                core_d.rdata[STS_FULL] = keep_q.full;
                core_d.rdata[STS_MOD_LSB +: MOD_W] = keep_q.mod_id;
                core_d.rdata[STS_ISO] = keep_q.isolate;
                core_d.rdata[STS_RST] = tmr_asserted;
                core_d.rdata[STS_START] = core_q.startup_req;
                core_d.rdata[STS_REQ] = req_seen;
            end else if (i_bus.addr == ADDR_OPTIONS) begin
                core_d.rdata[OPT_SKIP] = keep_q.skip;
            end else if (cfg_hit) begin
                core_d.rdata[CFG_START_EN] = keep_q.cfg[cfg_idx].start_en;
                core_d.rdata[CFG_RST_EN] = keep_q.cfg[cfg_idx].rst_en;
                core_d.rdata[CFG_RST_HIGH] = keep_q.cfg[cfg_idx].rst_high;
                core_d.rdata[CFG_DUR_LSB +: DUR_W] = keep_q.cfg[cfg_idx].dur;
            end
        end
    end

    // Occupancy, isolate level and per-module configuration
    always_comb begin
        keep_d = keep_q;
        if (core_q.state == ST_BOOT) begin
            // Held here through core reset, so any written value is lost
            keep_d.isolate = ~keep_q.full;
        end else if (ev_load_go) begin
            keep_d.isolate = 1'b1;
        end else if (ev_release) begin
            keep_d.isolate = 1'b0;
        end else if (ev_restart) begin
            keep_d.isolate = ~keep_q.full;
        end else if (in_shutdown && ctl_wr
                     && i_bus.wdata[CTL_ISO_WE]) begin
            keep_d.isolate = i_bus.wdata[CTL_ISO_VAL];
        end
        if (ev_load_go) begin
            keep_d.full = 1'b0;
        end
        if (ev_loaded) begin
            keep_d.full = 1'b1;
            keep_d.mod_id = core_q.load_id;
        end
        if (opt_wr) begin
            keep_d.skip = i_bus.wdata[OPT_SKIP];
        end
        if (i_bus.we && cfg_hit) begin
            keep_d.cfg[cfg_idx].start_en = i_bus.wdata[CFG_START_EN];
            keep_d.cfg[cfg_idx].rst_en = i_bus.wdata[CFG_RST_EN];
            keep_d.cfg[cfg_idx].rst_high = i_bus.wdata[CFG_RST_HIGH];
            keep_d.cfg[cfg_idx].dur = i_bus.wdata[CFG_DUR_LSB +: DUR_W];
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            core_q <= '0;
            core_q.state <= ST_BOOT;
        end else if (i_ce) begin
            core_q <= core_d;
        end
    end

    // Clocks during core reset so isolate settles while reset is held
    always_ff @(posedge i_clk or posedge i_power_on_reset) begin
        if (i_power_on_reset) begin
            keep_q <= '{full: FULL_RESET, mod_id: '0, isolate: ISO_RESET,
                        skip: SKIP_RESET,
                        cfg: {MOD_COUNT{CFG_RESET}}};
        end else if (i_ce) begin
            keep_q <= keep_d;
        end
    end

    assign o_rdata    = core_q.rdata;
    assign o_bs_ready = core_q.ready;
    assign o_cap_data = core_q.cap_data;
    assign o_cap_write = core_q.cap_we;
    assign o_module_startup_sw_request = core_q.startup_req;
    assign o_module_isolate = keep_q.isolate;
endmodule

/* File: msl_lc_asserts.sv */
// Port-level protocol checks for the lifecycle controller
`timescale 1ns/1ns
module msl_lc_asserts import msl_pkg::*; #(
    parameter logic [1:0] ARB_MODE = ARB_NO_LAT
) (
    // Watched ports
    input wire logic     i_clk,
    input wire logic     i_reset,
    input wire logic     i_power_on_reset,
    input wire msl_bus_t i_bus,
    input wire logic     i_cap_grant,
    input wire logic     i_cap_release,
    input wire logic     o_cap_req,
    input wire logic     o_cap_write,
    input wire logic     o_module_startup_sw_request,
    input wire logic     o_module_isolate,
    input wire logic     o_module_reset_out
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset || i_power_on_reset);

    a_xfer_has_grant: assert property (
        o_cap_write |-> $past(o_cap_req && i_cap_grant))
        else $error("word written without request and grant");
    a_write_has_req: assert property (
        o_cap_write |-> o_cap_req)
        else $error("request low while a word is written");
    a_write_spaced: assert property (
        o_cap_write |=> !o_cap_write)
        else $error("two words written back to back");
    a_release_holds_off: assert property (
        !o_cap_req && i_cap_release |=> !o_cap_req)
        else $error("request raised while release is high");
    a_mode2_req_drop: assert property (
        ARB_MODE == ARB_LAT && $fell(i_cap_grant) && o_cap_req
        |-> ##[0:2] !o_cap_req)
        else $error("request kept after grant fell");
    a_startup_proceed: assert property (
        $fell(o_module_startup_sw_request) |-> $past(i_bus.we
        && i_bus.addr == ADDR_CONTROL && i_bus.wdata[CTL_PROCEED]))
        else $error("start-up request dropped without proceed");
    a_iso_after_start: assert property (
        $fell(o_module_isolate) |-> !o_module_startup_sw_request)
        else $error("isolate released during start-up");
    a_core_rst_keep: assert property (
        disable iff (i_power_on_reset)
        i_reset && $past(i_reset) |-> $stable(o_module_reset_out))
        else $error("module reset moved during core reset");

    cover property (o_cap_write);
    cover property ($rose(o_module_startup_sw_request));
    cover property ($fell(o_module_isolate));
endmodule

bind msl_lifecycle_ctrl msl_lc_asserts #(.ARB_MODE(ARB_MODE)) u_chk (
    .i_clk, .i_reset, .i_power_on_reset, .i_bus, .i_cap_grant,
    .i_cap_release, .o_cap_req, .o_cap_write,
    .o_module_startup_sw_request, .o_module_isolate, .o_module_reset_out);

/* File: msl_arb_model.sv */
// Behavioural arbiter of the configuration access port
`timescale 1ns/1ns
module msl_arb_model (
    // Manager side
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_req,
    input  wire logic i_write,
    // Test controls: drop grant per word, competing agent
    input  wire logic i_drop,
    input  wire logic i_other,
    // Arbitration answer
    output logic      o_grant,
    output logic      o_release
);
    logic [1:0] wait_q;
    // Grant lags three cycles so the manager must hold its request
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_grant <= 1'b0;
            o_release <= 1'b0;
            wait_q <= 2'h0;
        end else begin
            wait_q <= (i_req && !o_grant) ? wait_q + 2'h1 : 2'h0;
            if (!i_req || (i_write && i_drop)) begin
                o_grant <= 1'b0;
            end else if (wait_q == 2'h2 && !i_other) begin
                o_grant <= 1'b1;
            end
            o_release <= i_other || (o_release && i_req);
        end
    end
endmodule

/* File: msl_lifecycle_ctrl_tb.sv */
// Self-checking bench for the lifecycle controller
`timescale 1ns/1ns
module msl_lifecycle_ctrl_tb import msl_pkg::*; ;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] e;
    } msl_row_t;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              por = 1'b1;
    logic              other = 1'b0;
    msl_bus_t          bus = '0;
    msl_bs_t           bs = '0;
    logic [DATA_W-1:0] rdata;
    logic [CAP_W-1:0]  cdata;
    logic [CAP_W-1:0]  last_w;
    logic              cwr, creq, gnt, rel, ready, sreq, iso, mrst;
    int                bad_count = 0;
    int                checks = 0;
    int                wcnt = 0;
    int                n;
    msl_row_t          rows [8] = '{'{8'h10, 32'h407}, '{8'h14, 32'h407},
        '{8'h18, 32'h407}, '{8'h1C, 32'h407}, '{ADDR_OPTIONS, 32'h0},
        '{ADDR_CONTROL, 32'h0}, '{8'h40, 32'h0}, '{ADDR_STATUS, 32'h1001}};

    always #20 clk = ~clk;
    always @(posedge clk) if (cwr) begin
        wcnt <= wcnt + 1;
        last_w <= cdata;
    end

    msl_lifecycle_ctrl #(.ARB_MODE(ARB_LAT)) dut (.i_clk(clk),
        .i_reset(rst), .i_power_on_reset(por), .i_ce(1'b1), .i_bus(bus),
        .o_rdata(rdata), .i_bs(bs), .o_bs_ready(ready), .o_cap_data(cdata),
        .o_cap_write(cwr), .o_cap_req(creq), .i_cap_grant(gnt),
        .i_cap_release(rel), .o_module_startup_sw_request(sreq),
        .o_module_isolate(iso), .o_module_reset_out(mrst));
    msl_arb_model arb (.i_clk(clk), .i_reset(por), .i_req(creq),
        .i_write(cwr), .i_drop(1'b1), .i_other(other), .o_grant(gnt),
        .o_release(rel));

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        chk("rdata", e, rdata);
    endtask
    // Selector: 0 start-up request, 1 isolate, 2 module reset
    task automatic wait_on(int sel, logic v);
        for (n = 0; n < 300; n++) begin
            @(negedge clk);
            if ((sel == 0 ? sreq : sel == 1 ? iso : mrst) === v) break;
        end
        chk("wait bound", 1, n < 300);
    endtask
    task automatic send(logic [31:0] d, logic l);
        @(posedge clk);
        bs <= '{d, 1'b1, l};
        // Look at ready off the edge; valid drops at the accepting edge
        @(negedge clk);
        for (n = 0; n < 300 && ready !== 1'b1; n++) @(negedge clk);
        chk("ready bound", 1, n < 300);
        @(posedge clk);
        bs <= '0;
    endtask
    task automatic results;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #(40 * 6000);
        bad_count++;
        results;
    end

    initial begin
        repeat (16) @(posedge clk);
        por <= 1'b0;
        rst <= 1'b0;
        foreach (rows[i]) rd(rows[i].a, rows[i].e);
        for (int k = 0; k < 2; k++) begin
            other <= (k == 1);
            wr(ADDR_CONTROL, 32'h2);
            @(negedge clk);
            chk("iso at load", 1, iso);
            repeat (6) @(negedge clk);
            if (k == 1) chk("req held off", 0, creq);
            other <= 1'b0;
            send(32'h1234_ABCD, 1'b0);
            send(32'hCAFE_0001, 1'b1);
            wait_on(0, 1'b1);
            chk("words", 2 * k + 2, wcnt);
            chk("last word", 32'hCAFE_0001, last_w);
            chk("iso start", 1, iso);
            chk("rst start", 0, mrst);
            wr(ADDR_CONTROL, 32'h1);
            wait_on(1, 1'b0);
            chk("rst with iso", 0, mrst);
            @(negedge clk);
            for (n = 0; n < 20 && mrst === 1'b1; n++) @(negedge clk);
            chk("rst length", 4, n);
            repeat (2) @(negedge clk);
        end
        wr(ADDR_CONTROL, 32'h4);
        wr(ADDR_CONTROL, 32'h30);
        @(negedge clk);
        chk("iso written", 1, iso);
        wr(ADDR_CONTROL, 32'hC0);
        @(negedge clk);
        chk("rst written", 1, mrst);
        wr(ADDR_CONTROL, 32'h80);
        wr(ADDR_CONTROL, 32'h8);
        @(negedge clk);
        chk("iso restart", 0, iso);
        // Written isolate level must be overridden by the core reset
        wr(ADDR_CONTROL, 32'h4);
        wr(ADDR_CONTROL, 32'h30);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(negedge clk);
        chk("iso core rst", 0, iso);
        chk("rst core rst", 0, mrst);
        @(posedge clk);
        rst <= 1'b0;
        wait_on(0, 1'b1);
        chk("iso start full", 0, iso);
        wr(ADDR_CONTROL, 32'h1);
        wait_on(2, 1'b1);
        chk("iso after core rst", 0, iso);
        wait_on(2, 1'b0);
        wr(ADDR_OPTIONS, 32'h1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(negedge clk);
        chk("skip start", 0, sreq);
        chk("skip reset", 0, mrst);
        rd(ADDR_STATUS, 32'h11);
        results;
    end
endmodule
